/* common/cfr_pkg.sv */
// constants for the receive filter configuration register bank
package cfr_pkg;

  // ---------------------------------------------------------------
  // bus geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NFLAGS = 30;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IRQ_FLAG_EN = 8'h54;
  localparam logic [7:0] OFS_IRQ_LINE_SEL = 8'h58;
  localparam logic [7:0] OFS_IRQ_LINE_EN = 8'h5C;
  localparam logic [7:0] OFS_GLOBAL_FILTER = 8'h80;
  localparam logic [7:0] OFS_STD_FILTER = 8'h84;
  localparam logic [7:0] OFS_EXT_FILTER = 8'h88;
  localparam logic [7:0] OFS_EXT_MASK = 8'h90;
  localparam logic [7:0] OFS_PRIO_STATUS = 8'h94;
  localparam logic [7:0] OFS_NEW_DATA_LOW = 8'h98;
  localparam logic [7:0] OFS_NEW_DATA_HIGH = 8'h9C;
  localparam logic [7:0] OFS_RX_FIFO0_CFG = 8'hA0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int LINE0_EN_BIT = 0;
  localparam int LINE1_EN_BIT = 1;
  localparam int NOMATCH_STD_LSB = 4;
  localparam int NOMATCH_EXT_LSB = 2;
  localparam int REJ_RMT_STD_BIT = 1;
  localparam int REJ_RMT_EXT_BIT = 0;
  localparam int LIST_LEN_LSB = 16;
  localparam int LIST_BASE_LSB = 2;

  // ---------------------------------------------------------------
  // write masks, reset values, limits
  // ---------------------------------------------------------------
  localparam logic [31:0] STD_FILTER_WMASK = 32'h00FF_FFFC;
  localparam logic [31:0] EXT_FILTER_WMASK = 32'h007F_FFFC;
  localparam logic [31:0] RX_FIFO0_WMASK = 32'hFF7F_FFFC;
  localparam logic [28:0] EXT_MASK_RESET = 29'h1FFF_FFFF;
  localparam logic [7:0] STD_LEN_MAX = 8'h80;
  localparam logic [6:0] EXT_LEN_MAX = 7'h40;
  localparam logic [1:0] ACT_FIFO0 = 2'h0;
  localparam logic [1:0] ACT_FIFO1 = 2'h1;

  // ---------------------------------------------------------------
  // bus responses
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CFR_SEL_NONE, CFR_SEL_FLAG_EN, CFR_SEL_LINE_SEL, CFR_SEL_LINE_EN, CFR_SEL_POLICY,
    CFR_SEL_STD, CFR_SEL_EXT, CFR_SEL_MASK, CFR_SEL_PRIO, CFR_SEL_NEW_LO,
    CFR_SEL_NEW_HI, CFR_SEL_FIFO0
  } cfr_sel_e;

endpackage

/* design/cfr_regs.sv */
// receive filter configuration and status register bank, AXI4-Lite slave
//
// Contract
// - line enable bits gate both interrupt outputs
// - standard non-matching frames: fifo0, fifo1, discard
// - extended non-matching frames: same three-way coding
// - reject bit drops standard remote frames
// - reject bit drops extended remote frames
// - standard list length saturates at 128
// - standard list base from bits 15:2
// - extended list length saturates at 64
// - extended list base from bits 15:2
// - extended identifier ANDed with 29-bit mask
// - mask resets to all ones
// - priority status rewritten on every priority match
// - bit 15 reports matching list
// - bits 14:8 hold matching element index
// - bits 7:6 report storage outcome
// - bits 5:0 hold stored fifo index
// - low new-data flags set on update, sticky
// - high new-data flags behave the same
// - writing one clears flag, zero no effect
// - hard reset clears all new-data flags
// - line-select bit routes each flag
// - flag forwarded only while its enable set
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ps
module cfr_regs (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [cfr_pkg::ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [cfr_pkg::DATA_W-1:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [cfr_pkg::ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  output logic RVALID,
  input wire logic RREADY,
  output logic [cfr_pkg::DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  input wire logic [cfr_pkg::NFLAGS-1:0] IRQ_FLAGS,
  output logic IRQ_OUT_ZERO,
  output logic IRQ_OUT_ONE,
  input wire logic FRM_VALID,
  input wire logic FRM_XTD,
  input wire logic FRM_RMT,
  input wire logic FRM_NOMATCH,
  output logic ACT_VALID,
  output logic ACT_FILTER,
  output logic ACT_STORE0,
  output logic ACT_STORE1,
  output logic ACT_DISCARD,
  input wire logic EXT_ID_VALID,
  input wire logic [28:0] EXT_ID,
  output logic MASKED_ID_VALID,
  output logic [28:0] MASKED_EXT_ID,
  output logic [7:0] STD_LIST_LEN,
  output logic [13:0] STD_LIST_BASE,
  output logic [6:0] EXT_LIST_LEN,
  output logic [13:0] EXT_LIST_BASE,
  output logic [31:0] RX_FIFO0_CFG,
  input wire logic HP_EVT,
  input wire logic HP_LIST,
  input wire logic [6:0] HP_INDEX,
  input wire logic [1:0] HP_STORE,
  input wire logic [5:0] HP_BUF,
  input wire logic [63:0] BUF_UPDATE,
  output logic [63:0] NEW_DATA
);
  import cfr_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [NFLAGS-1:0] flag_en;
    logic [NFLAGS-1:0] line_sel;
    logic [1:0] line_en;
    logic [5:0] filt_pol;
    logic [31:0] std_cfg;
    logic [31:0] ext_cfg;
    logic [28:0] id_mask;
    logic [15:0] prio_stat;
    logic [63:0] new_data;
    logic [31:0] fifo0;
    logic [7:0] std_len;
    logic [6:0] ext_len;
    logic irq0;
    logic irq1;
    logic act_valid;
    logic act_filter;
    logic act_store0;
    logic act_store1;
    logic act_discard;
    logic mask_valid;
    logic [28:0] mask_id;
  } cfr_state_s;

  cfr_state_s state_reg;
  cfr_state_s state_next;
  logic wr_fire;
  logic [63:0] new_data_clr;
  logic [1:0] nm_act;
  logic rmt_rej;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic cfr_sel_e decode(input logic [ADDR_W-1:0] a);
    cfr_sel_e sel;
    sel = CFR_SEL_NONE;
    unique case (a)
      OFS_IRQ_FLAG_EN: sel = CFR_SEL_FLAG_EN;
      OFS_IRQ_LINE_SEL: sel = CFR_SEL_LINE_SEL;
      OFS_IRQ_LINE_EN: sel = CFR_SEL_LINE_EN;
      OFS_GLOBAL_FILTER: sel = CFR_SEL_POLICY;
      OFS_STD_FILTER: sel = CFR_SEL_STD;
      OFS_EXT_FILTER: sel = CFR_SEL_EXT;
      OFS_EXT_MASK: sel = CFR_SEL_MASK;
      OFS_PRIO_STATUS: sel = CFR_SEL_PRIO;
      OFS_NEW_DATA_LOW: sel = CFR_SEL_NEW_LO;
      OFS_NEW_DATA_HIGH: sel = CFR_SEL_NEW_HI;
      OFS_RX_FIFO0_CFG: sel = CFR_SEL_FIFO0;
      default: sel = CFR_SEL_NONE;
    endcase
    return sel;
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // byte-lane merge under a field write mask
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb, input logic [31:0] wm);
    logic [31:0] m;
    m = lanes(strb) & wm;
    return (old & ~m) | (d & m);
  endfunction

  function automatic logic [31:0] read_word(input cfr_state_s st, input cfr_sel_e sel);
    logic [31:0] d;
    d = '0;
    unique case (sel)
      CFR_SEL_FLAG_EN: d = {2'h0, st.flag_en};
      CFR_SEL_LINE_SEL: d = {2'h0, st.line_sel};
      CFR_SEL_LINE_EN: d = {30'h0, st.line_en};
      CFR_SEL_POLICY: d = {26'h0, st.filt_pol};
      CFR_SEL_STD: d = st.std_cfg;
      CFR_SEL_EXT: d = st.ext_cfg;
      CFR_SEL_MASK: d = {3'h0, st.id_mask};
      CFR_SEL_PRIO: d = {16'h0, st.prio_stat};
      CFR_SEL_NEW_LO: d = st.new_data[31:0];
      CFR_SEL_NEW_HI: d = st.new_data[63:32];
      CFR_SEL_FIFO0: d = st.fifo0;
      CFR_SEL_NONE: d = '0;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    wv = '0;
    state_next = state_reg;
    new_data_clr = '0;
    wr_fire = state_reg.aw_got && state_reg.w_got && !state_reg.bvalid;
    if (AWVALID && state_reg.awready) begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = AWADDR;
    end
    if (WVALID && state_reg.wready) begin
      state_next.w_got = 1'b1;
      state_next.w_data = WDATA;
      state_next.w_strb = WSTRB;
    end
    if (BREADY && state_reg.bvalid) begin
      state_next.bvalid = 1'b0;
    end
    if (wr_fire) begin
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = RESP_OKAY;
      unique case (decode(state_reg.aw_addr))
        CFR_SEL_FLAG_EN: begin
          wv = merge({2'h0, state_reg.flag_en}, state_reg.w_data, state_reg.w_strb, '1);
          state_next.flag_en = wv[NFLAGS-1:0];
        end
        CFR_SEL_LINE_SEL: begin
          wv = merge({2'h0, state_reg.line_sel}, state_reg.w_data, state_reg.w_strb, '1);
          state_next.line_sel = wv[NFLAGS-1:0];
        end
        CFR_SEL_LINE_EN: begin
          wv = merge({30'h0, state_reg.line_en}, state_reg.w_data, state_reg.w_strb, '1);
          state_next.line_en = wv[1:0];
        end
        CFR_SEL_POLICY: begin
          wv = merge({26'h0, state_reg.filt_pol}, state_reg.w_data, state_reg.w_strb, '1);
          state_next.filt_pol = wv[5:0];
        end
        CFR_SEL_STD: begin
          state_next.std_cfg = merge(state_reg.std_cfg, state_reg.w_data, state_reg.w_strb,
                                     STD_FILTER_WMASK);
        end
        CFR_SEL_EXT: begin
          state_next.ext_cfg = merge(state_reg.ext_cfg, state_reg.w_data, state_reg.w_strb,
                                     EXT_FILTER_WMASK);
        end
        CFR_SEL_MASK: begin
          wv = merge({3'h0, state_reg.id_mask}, state_reg.w_data, state_reg.w_strb, '1);
          state_next.id_mask = wv[28:0];
        end
        CFR_SEL_FIFO0: begin
          state_next.fifo0 = merge(state_reg.fifo0, state_reg.w_data, state_reg.w_strb,
                                   RX_FIFO0_WMASK);
        end
        CFR_SEL_NEW_LO: new_data_clr[31:0] = state_reg.w_data & lanes(state_reg.w_strb);
        CFR_SEL_NEW_HI: new_data_clr[63:32] = state_reg.w_data & lanes(state_reg.w_strb);
        CFR_SEL_PRIO: state_next.bresp = RESP_OKAY;
        CFR_SEL_NONE: state_next.bresp = RESP_SLVERR;
      endcase
    end
    state_next.awready = !state_next.aw_got && !state_next.bvalid;
    state_next.wready = !state_next.w_got && !state_next.bvalid;

    if (RREADY && state_reg.rvalid) begin
      state_next.rvalid = 1'b0;
    end
    if (ARVALID && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata = read_word(state_reg, decode(ARADDR));
      state_next.rresp = (decode(ARADDR) == CFR_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    state_next.arready = !state_next.rvalid;

    state_next.new_data = (state_reg.new_data & ~new_data_clr) | BUF_UPDATE;

    if (HP_EVT) begin
      state_next.prio_stat = {HP_LIST, HP_INDEX, HP_STORE, HP_BUF};
    end

    state_next.std_len = (state_next.std_cfg[LIST_LEN_LSB +: 8] > STD_LEN_MAX) ?
                         STD_LEN_MAX : state_next.std_cfg[LIST_LEN_LSB +: 8];
    state_next.ext_len = (state_next.ext_cfg[LIST_LEN_LSB +: 7] > EXT_LEN_MAX) ?
                         EXT_LEN_MAX : state_next.ext_cfg[LIST_LEN_LSB +: 7];

    state_next.irq0 = state_reg.line_en[LINE0_EN_BIT] &&
                      |(IRQ_FLAGS & state_reg.flag_en & ~state_reg.line_sel);
    state_next.irq1 = state_reg.line_en[LINE1_EN_BIT] &&
                      |(IRQ_FLAGS & state_reg.flag_en & state_reg.line_sel);

    rmt_rej = FRM_RMT && (FRM_XTD ? state_reg.filt_pol[REJ_RMT_EXT_BIT] :
                                    state_reg.filt_pol[REJ_RMT_STD_BIT]);
    nm_act = FRM_XTD ? state_reg.filt_pol[NOMATCH_EXT_LSB +: 2] :
                       state_reg.filt_pol[NOMATCH_STD_LSB +: 2];
    state_next.act_valid = FRM_VALID;
    state_next.act_filter = FRM_VALID && !rmt_rej && !FRM_NOMATCH;
    state_next.act_store0 = FRM_VALID && !rmt_rej && FRM_NOMATCH && nm_act == ACT_FIFO0;
    state_next.act_store1 = FRM_VALID && !rmt_rej && FRM_NOMATCH && nm_act == ACT_FIFO1;
    state_next.act_discard = FRM_VALID && (rmt_rej || (FRM_NOMATCH && nm_act[1]));

    state_next.mask_valid = EXT_ID_VALID;
    state_next.mask_id = EXT_ID & state_reg.id_mask;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
      state_reg.id_mask <= EXT_MASK_RESET;
      state_reg.new_data <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign AWREADY = state_reg.awready;
  assign WREADY = state_reg.wready;
  assign BVALID = state_reg.bvalid;
  assign BRESP = state_reg.bresp;
  assign ARREADY = state_reg.arready;
  assign RVALID = state_reg.rvalid;
  assign RDATA = state_reg.rdata;
  assign RRESP = state_reg.rresp;
  assign IRQ_OUT_ZERO = state_reg.irq0;
  assign IRQ_OUT_ONE = state_reg.irq1;
  assign ACT_VALID = state_reg.act_valid;
  assign ACT_FILTER = state_reg.act_filter;
  assign ACT_STORE0 = state_reg.act_store0;
  assign ACT_STORE1 = state_reg.act_store1;
  assign ACT_DISCARD = state_reg.act_discard;
  assign MASKED_ID_VALID = state_reg.mask_valid;
  assign MASKED_EXT_ID = state_reg.mask_id;
  assign STD_LIST_LEN = state_reg.std_len;
  assign STD_LIST_BASE = state_reg.std_cfg[LIST_BASE_LSB +: 14];
  assign EXT_LIST_LEN = state_reg.ext_len;
  assign EXT_LIST_BASE = state_reg.ext_cfg[LIST_BASE_LSB +: 14];
  assign RX_FIFO0_CFG = state_reg.fifo0;
  assign NEW_DATA = state_reg.new_data;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);

  a_line0_gate: assert property (!state_reg.line_en[0] |=> !IRQ_OUT_ZERO)
    else $error("line zero active while disabled");
  a_line1_or: assert property (
    (state_reg.line_en[1] && |(IRQ_FLAGS & state_reg.flag_en & state_reg.line_sel))
    |=> IRQ_OUT_ONE)
    else $error("line one missed an enabled flag");
  a_route_zero: assert property (
    ((IRQ_FLAGS & state_reg.flag_en & ~state_reg.line_sel) == '0) |=> !IRQ_OUT_ZERO)
    else $error("line zero raised without routed flag");
  a_flag_enable: assert property ((state_reg.flag_en == '0) |=> !IRQ_OUT_ONE)
    else $error("disabled flag reached line one");
  a_std_nomatch_fifo1: assert property (
    (FRM_VALID && !FRM_XTD && !FRM_RMT && FRM_NOMATCH && state_reg.filt_pol[5:4] == 2'h1)
    |=> ACT_STORE1 && !ACT_DISCARD)
    else $error("standard non-match not sent to fifo 1");
  a_ext_nomatch_drop: assert property (
    (FRM_VALID && FRM_XTD && !FRM_RMT && FRM_NOMATCH && state_reg.filt_pol[3])
    |=> ACT_DISCARD && !ACT_STORE0 && !ACT_STORE1)
    else $error("extended non-match not discarded");
  a_std_remote_rej: assert property (
    (FRM_VALID && !FRM_XTD && FRM_RMT && state_reg.filt_pol[1]) |=> ACT_DISCARD && !ACT_FILTER)
    else $error("standard remote frame not rejected");
  a_ext_remote_rej: assert property (
    (FRM_VALID && FRM_XTD && FRM_RMT && state_reg.filt_pol[0]) |=> ACT_DISCARD && !ACT_FILTER)
    else $error("extended remote frame not rejected");
  a_std_len_cap: assert property (
    $past(wr_fire) |=> STD_LIST_LEN <= 8'h80)
    else $error("standard length above limit");
  a_ext_len_cap: assert property (EXT_LIST_LEN <= 7'h40)
    else $error("extended length above limit");
  a_mask_apply: assert property (
    EXT_ID_VALID |=> MASKED_ID_VALID &&
    MASKED_EXT_ID == ($past(EXT_ID) & $past(state_reg.id_mask)))
    else $error("masked identifier wrong");
  a_prio_load: assert property (
    HP_EVT |=> state_reg.prio_stat == $past({HP_LIST, HP_INDEX, HP_STORE, HP_BUF}))
    else $error("priority status not rewritten");
  a_nd_sticky: assert property (
    (BUF_UPDATE != '0) |=> ((NEW_DATA & $past(BUF_UPDATE)) == $past(BUF_UPDATE)))
    else $error("new data flag not set");
  a_nd_hold: assert property (
    (BUF_UPDATE == '0 && !wr_fire) |=> NEW_DATA == $past(NEW_DATA))
    else $error("new data flags changed without cause");

  c_write_done: cover property (wr_fire ##[1:4] (BVALID && BREADY));
  c_read_done: cover property ((ARVALID && ARREADY) ##1 RVALID);
  c_prio_event: cover property (HP_EVT ##1 state_reg.prio_stat[15]);
  c_irq_zero: cover property (IRQ_OUT_ZERO);
endmodule

/* verification/can_rx_filter_config_regs_tb.sv */
// self-checking bench for the receive filter configuration register bank
`timescale 1ns/1ps
module can_rx_filter_config_regs_tb;
  import cfr_pkg::*;

  logic CLK = 0, ARST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic FRM_VALID = 0, FRM_XTD = 0, FRM_RMT = 0, FRM_NOMATCH = 0, EXT_ID_VALID = 0;
  logic HP_EVT = 0, HP_LIST = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [2:0] AWPROT = 0, ARPROT = 0;
  logic [31:0] WDATA = 0;
  logic [3:0] WSTRB = 0;
  logic [29:0] IRQ_FLAGS = 0;
  logic [28:0] EXT_ID = 0;
  logic [6:0] HP_INDEX = 0;
  logic [1:0] HP_STORE = 0;
  logic [5:0] HP_BUF = 0;
  logic [63:0] BUF_UPDATE = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ_OUT_ZERO, IRQ_OUT_ONE, MASKED_ID_VALID;
  logic ACT_VALID, ACT_FILTER, ACT_STORE0, ACT_STORE1, ACT_DISCARD;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA, RX_FIFO0_CFG;
  logic [28:0] MASKED_EXT_ID, m;
  logic [7:0] STD_LIST_LEN;
  logic [13:0] STD_LIST_BASE, EXT_LIST_BASE;
  logic [6:0] EXT_LIST_LEN;
  logic [63:0] NEW_DATA, s, flags_exp;
  logic [31:0] d;
  logic [29:0] e, sl, f;
  logic [1:0] l;
  int i, j, n_mismatch = 0, cmp_count = 0, seed = 244;
  localparam logic [7:0] SC [8] = '{8'h00, 8'h01, 8'h7F, 8'h80, 8'h81, 8'hC8, 8'hFF, 8'h40};
  localparam logic [6:0] EC [8] = '{7'h00, 7'h01, 7'h3F, 7'h40, 7'h41, 7'h64, 7'h7F, 7'h20};

  cfr_regs cfr_regs_inst (
    .CLK(CLK), .ARST_N(ARST_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .AWPROT(AWPROT), .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .BVALID(BVALID), .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .ARPROT(ARPROT), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA),
    .RRESP(RRESP), .IRQ_FLAGS(IRQ_FLAGS), .IRQ_OUT_ZERO(IRQ_OUT_ZERO),
    .IRQ_OUT_ONE(IRQ_OUT_ONE), .FRM_VALID(FRM_VALID), .FRM_XTD(FRM_XTD), .FRM_RMT(FRM_RMT),
    .FRM_NOMATCH(FRM_NOMATCH), .ACT_VALID(ACT_VALID), .ACT_FILTER(ACT_FILTER),
    .ACT_STORE0(ACT_STORE0), .ACT_STORE1(ACT_STORE1), .ACT_DISCARD(ACT_DISCARD),
    .EXT_ID_VALID(EXT_ID_VALID), .EXT_ID(EXT_ID), .MASKED_ID_VALID(MASKED_ID_VALID),
    .MASKED_EXT_ID(MASKED_EXT_ID), .STD_LIST_LEN(STD_LIST_LEN), .STD_LIST_BASE(STD_LIST_BASE),
    .EXT_LIST_LEN(EXT_LIST_LEN), .EXT_LIST_BASE(EXT_LIST_BASE), .RX_FIFO0_CFG(RX_FIFO0_CFG),
    .HP_EVT(HP_EVT), .HP_LIST(HP_LIST), .HP_INDEX(HP_INDEX), .HP_STORE(HP_STORE),
    .HP_BUF(HP_BUF), .BUF_UPDATE(BUF_UPDATE), .NEW_DATA(NEW_DATA)
  );

  // ---------------------------------------------------------------
  // clock and watchdog
  // ---------------------------------------------------------------
  initial begin
    forever #10 CLK = ~CLK;
  end

  initial begin
    #(20 * 20000);
    n_mismatch++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [1:0] er);
    logic aw, w;
    aw = 0;
    w = 0;
    @(posedge CLK);
    AWVALID <= 1;
    AWADDR <= a;
    WVALID <= 1;
    WDATA <= dat;
    WSTRB <= 4'hF;
    BREADY <= 1;
    while (!(aw && w)) begin
      @(posedge CLK);
      if (!aw && AWREADY) begin
        aw = 1;
        AWVALID <= 0;
      end
      if (!w && WREADY) begin
        w = 1;
        WVALID <= 0;
      end
    end
    while (!BVALID) @(posedge CLK);
    BREADY <= 0;
    chk(BRESP, er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge CLK);
    ARVALID <= 1;
    ARADDR <= a;
    RREADY <= 1;
    @(posedge CLK);
    while (!ARREADY) @(posedge CLK);
    ARVALID <= 0;
    @(posedge CLK);
    while (!RVALID) @(posedge CLK);
    RREADY <= 0;
    chk({RRESP, RDATA}, {er, ed});
  endtask

  // one frame decision, outputs looked at in their one-cycle pulse
  task automatic frm(input logic x, input logic r, input logic n, input logic [3:0] ea);
    @(posedge CLK);
    FRM_VALID <= 1;
    {FRM_XTD, FRM_RMT, FRM_NOMATCH} <= {x, r, n};
    @(posedge CLK);
    FRM_VALID <= 0;
    #1 chk({ACT_VALID, ACT_FILTER, ACT_STORE0, ACT_STORE1, ACT_DISCARD}, {1'b1, ea});
  endtask

  // expected {filter, store0, store1, discard}
  function automatic logic [3:0] act_exp(input logic x, r, n, input logic [5:0] g);
    logic [1:0] c;
    c = x ? g[3:2] : g[5:4];
    if (r && (x ? g[0] : g[1]))
      return 4'h1;
    if (!n)
      return 4'h8;
    if (c == 2'h0)
      return 4'h4;
    if (c == 2'h1)
      return 4'h2;
    return 4'h1;
  endfunction

  function automatic logic [1:0] irq_exp(input logic [29:0] fl, en, se, input logic [1:0] le);
    return {le[1] & |(fl & en & se), le[0] & |(fl & en & ~se)};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    ARST_N <= 1;
    rd(OFS_EXT_MASK, 32'h1FFF_FFFF, RESP_OKAY);
    rd(OFS_NEW_DATA_LOW, 32'h0, RESP_OKAY);
    rd(OFS_NEW_DATA_HIGH, 32'h0, RESP_OKAY);
    rd(8'h60, 32'h0, RESP_SLVERR);
    wr(8'h60, $random(seed), RESP_SLVERR);
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      d[23:16] = SC[i];
      wr(OFS_STD_FILTER, d, RESP_OKAY);
      rd(OFS_STD_FILTER, d & STD_FILTER_WMASK, RESP_OKAY);
      chk(STD_LIST_LEN, (SC[i] > 8'h80) ? 8'h80 : SC[i]);
      chk(STD_LIST_BASE, d[15:2]);
      d = $random(seed);
      d[22:16] = EC[i];
      wr(OFS_EXT_FILTER, d, RESP_OKAY);
      rd(OFS_EXT_FILTER, d & EXT_FILTER_WMASK, RESP_OKAY);
      chk(EXT_LIST_LEN, (EC[i] > 7'h40) ? 7'h40 : EC[i]);
      chk(EXT_LIST_BASE, d[15:2]);
    end
    d = $random(seed);
    wr(OFS_RX_FIFO0_CFG, d, RESP_OKAY);
    rd(OFS_RX_FIFO0_CFG, d & RX_FIFO0_WMASK, RESP_OKAY);
    chk(RX_FIFO0_CFG, d & RX_FIFO0_WMASK);
    // every policy code, every frame kind
    for (i = 0; i < 64; i++) begin
      d = $random(seed);
      d[5:0] = i[5:0];
      wr(OFS_GLOBAL_FILTER, d, RESP_OKAY);
      rd(OFS_GLOBAL_FILTER, {26'h0, d[5:0]}, RESP_OKAY);
      for (j = 0; j < 8; j++)
        frm(j[2], j[1], j[0], act_exp(j[2], j[1], j[0], d[5:0]));
    end
    for (i = 0; i < 8; i++) begin
      m = (i == 0) ? 29'h0 : $random(seed);
      wr(OFS_EXT_MASK, {3'h7, m}, RESP_OKAY);
      rd(OFS_EXT_MASK, {3'h0, m}, RESP_OKAY);
      @(posedge CLK);
      EXT_ID_VALID <= 1;
      EXT_ID <= $random(seed);
      @(posedge CLK);
      EXT_ID_VALID <= 0;
      #1 chk({MASKED_ID_VALID, MASKED_EXT_ID}, {1'b1, EXT_ID & m});
    end
    for (i = 0; i < 8; i++) begin
      d = $random(seed);
      @(posedge CLK);
      HP_EVT <= 1;
      {HP_LIST, HP_INDEX, HP_STORE, HP_BUF} <= d[15:0];
      @(posedge CLK);
      HP_EVT <= 0;
      rd(OFS_PRIO_STATUS, {16'h0, d[15:0]}, RESP_OKAY);
    end
    wr(OFS_PRIO_STATUS, ~d, RESP_OKAY);
    rd(OFS_PRIO_STATUS, {16'h0, d[15:0]}, RESP_OKAY);
    // sticky flags, write one to clear
    flags_exp = '0;
    for (i = 0; i < 4; i++) begin
      s = {$random(seed), $random(seed)};
      @(posedge CLK);
      BUF_UPDATE <= s;
      @(posedge CLK);
      BUF_UPDATE <= '0;
      flags_exp = flags_exp | s;
      #1 chk(NEW_DATA, flags_exp);
      d = $random(seed);
      wr(OFS_NEW_DATA_LOW, d, RESP_OKAY);
      flags_exp[31:0] = flags_exp[31:0] & ~d;
      d = $random(seed);
      wr(OFS_NEW_DATA_HIGH, d, RESP_OKAY);
      flags_exp[63:32] = flags_exp[63:32] & ~d;
      rd(OFS_NEW_DATA_LOW, flags_exp[31:0], RESP_OKAY);
      rd(OFS_NEW_DATA_HIGH, flags_exp[63:32], RESP_OKAY);
    end
    for (i = 0; i < 16; i++) begin
      e = $random(seed);
      sl = $random(seed);
      f = $random(seed) & $random(seed) & $random(seed);
      l = i[1:0];
      wr(OFS_IRQ_FLAG_EN, {2'h3, e}, RESP_OKAY);
      wr(OFS_IRQ_LINE_SEL, {2'h3, sl}, RESP_OKAY);
      wr(OFS_IRQ_LINE_EN, {30'h3FFF_FFFF, l}, RESP_OKAY);
      rd(OFS_IRQ_LINE_EN, {30'h0, l}, RESP_OKAY);
      @(posedge CLK);
      IRQ_FLAGS <= f;
      repeat (2) @(posedge CLK);
      #1 chk({IRQ_OUT_ONE, IRQ_OUT_ZERO}, irq_exp(f, e, sl, l));
    end
    finish_test();
  end
endmodule
